// *** msi_status_indicators.sv ***
`default_nettype none
module msi_status_indicators
  import msi_pkg::*;
#(
  parameter int MS_CYCLES = MS_CYCLES_DFLT
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // network state
  input wire logic net_searching,
  input wire logic net_registered,
  input wire logic data_active,
  input wire logic voice_call,
  output logic network_indicator,
  // operation status
  input wire logic powerup_done,
  output logic status_out,
  // unsolicited results and ring
  input wire logic [URC_PORTS-1:0] urc_event,
  output logic ring_indicator_out,
  // deep sleep
  input wire logic cmd_airplane_on,
  input wire logic cmd_psm_enable,
  input wire logic cmd_airplane_off,
  input wire logic wake_timer_expired,
  input wire logic sleep_wake_input,
  output logic sleep_mode_indicator,
  // host ready pin
  input wire logic host_ready_input,
  output logic host_ready,
  output logic pins_configured
);

  localparam logic [TICK_W-1:0] MS_LAST = TICK_W'(MS_CYCLES - 1);

  ////////////////////////////////////////////////////////////////////////
  // millisecond tick
  logic [TICK_W-1:0] tick_cnt_q;
  logic tick;

  assign tick = (tick_cnt_q == MS_LAST);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tick_cnt_q <= '0;
    end else if (tick) begin
      tick_cnt_q <= '0;
    end else begin
      tick_cnt_q <= tick_cnt_q + TICK_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // power-up pin phase
  msi_pu_e pu_q;
  logic [MS_W-1:0] pu_cnt_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pu_q <= PU_HIGH;
      pu_cnt_q <= MS_ZERO;
    end else if (tick) begin
      unique case (pu_q)
        PU_HIGH: begin
          if (pu_cnt_q + MS_ONE == PWRUP_HIGH_MS) begin
            pu_q <= PU_LOW;
            pu_cnt_q <= MS_ZERO;
          end else begin
            pu_cnt_q <= pu_cnt_q + MS_ONE;
          end
        end
        PU_LOW: begin
          if (pu_cnt_q + MS_ONE == PWRUP_LOW_MS) begin
            pu_q <= PU_RUN;
            pu_cnt_q <= MS_ZERO;
          end else begin
            pu_cnt_q <= pu_cnt_q + MS_ONE;
          end
        end
        PU_RUN: begin
          pu_cnt_q <= MS_ZERO;
        end
      endcase
    end
  end

  assign pins_configured = (pu_q == PU_RUN);

  // host ready only trusted once the pin is configured
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      host_ready <= 1'b0;
    end else begin
      host_ready <= pins_configured & host_ready_input;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // network indicator
  msi_net_e mode_d, mode_q;
  logic [MS_W-1:0] net_cnt_q;
  logic phase_q;
  logic [MS_W-1:0] first_len, second_len;

  always_comb begin
    if (voice_call) begin
      mode_d = NET_VOICE;
    end else if (data_active) begin
      mode_d = NET_DATA;
    end else if (net_registered) begin
      mode_d = NET_REG;
    end else if (net_searching) begin
      mode_d = NET_SEARCH;
    end else begin
      mode_d = NET_OFF;
    end
  end

  always_comb begin
    unique case (mode_q)
      NET_SEARCH: begin
        first_len = SEARCH_HIGH_MS;
        second_len = SEARCH_LOW_MS;
      end
      NET_REG: begin
        first_len = REG_HIGH_MS;
        second_len = REG_LOW_MS;
      end
      NET_DATA: begin
        first_len = DATA_LOW_MS;
        second_len = DATA_HIGH_MS;
      end
      default: begin
        first_len = MS_ONE;
        second_len = MS_ONE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode_q <= NET_OFF;
      net_cnt_q <= MS_ZERO;
      phase_q <= 1'b0;
    end else if (mode_d != mode_q) begin
      mode_q <= mode_d;
      net_cnt_q <= MS_ZERO;
      phase_q <= 1'b0;
    end else if (tick) begin
      if (net_cnt_q + MS_ONE == (phase_q ? second_len : first_len)) begin
        net_cnt_q <= MS_ZERO;
        phase_q <= ~phase_q;
      end else begin
        net_cnt_q <= net_cnt_q + MS_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      network_indicator <= 1'b0;
    end else begin
      unique case (mode_q)
        NET_SEARCH, NET_REG: network_indicator <= ~phase_q;
        NET_DATA: network_indicator <= phase_q;
        NET_VOICE: network_indicator <= 1'b1;
        NET_OFF: network_indicator <= 1'b0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // operation status
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      status_out <= 1'b0;
    end else if (powerup_done) begin
      status_out <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // ring indicator pulse; a fresh result restarts the pulse
  logic ri_busy_q;
  logic [MS_W-1:0] ri_cnt_q;
  logic urc_any;

  assign urc_any = |urc_event;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ri_busy_q <= 1'b0;
      ri_cnt_q <= MS_ZERO;
    end else if (pins_configured && urc_any) begin
      ri_busy_q <= 1'b1;
      ri_cnt_q <= MS_ZERO;
    end else if (ri_busy_q && tick) begin
      if (ri_cnt_q + MS_ONE == RI_LOW_MS) begin
        ri_busy_q <= 1'b0;
        ri_cnt_q <= MS_ZERO;
      end else begin
        ri_cnt_q <= ri_cnt_q + MS_ONE;
      end
    end
  end

  always_comb begin
    unique case (pu_q)
      PU_HIGH: ring_indicator_out = 1'b1;
      PU_LOW: ring_indicator_out = 1'b0;
      PU_RUN: ring_indicator_out = ~ri_busy_q;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // deep sleep sequence
  msi_sleep_e sleep_q;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_q <= SLP_NORMAL;
    end else begin
      unique case (sleep_q)
        SLP_NORMAL: if (cmd_airplane_on) sleep_q <= SLP_AIRPLANE;
        SLP_AIRPLANE: begin
          if (cmd_psm_enable) begin
            sleep_q <= SLP_ARMED;
          end else if (cmd_airplane_off) begin
            sleep_q <= SLP_NORMAL;
          end
        end
        SLP_ARMED: if (cmd_airplane_off) sleep_q <= SLP_DEEP;
        SLP_DEEP: if (sleep_wake_input || wake_timer_expired) sleep_q <= SLP_NORMAL;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sleep_mode_indicator <= 1'b0;
    end else begin
      sleep_mode_indicator <= (sleep_q == SLP_DEEP);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks
  a_search_high: assert property (@(posedge clk) disable iff (!rst_b)
    mode_q == NET_SEARCH && !phase_q |-> net_cnt_q < SEARCH_HIGH_MS)
    else $error("search high phase too long");
  a_reg_low: assert property (@(posedge clk) disable iff (!rst_b)
    mode_q == NET_REG && phase_q |-> net_cnt_q < REG_LOW_MS)
    else $error("registered low phase too long");
  a_data_first_low: assert property (@(posedge clk) disable iff (!rst_b)
    mode_q == NET_DATA && !phase_q |=> !network_indicator)
    else $error("data pattern does not start low");
  a_voice_priority: assert property (@(posedge clk) disable iff (!rst_b)
    voice_call |=> mode_q == NET_VOICE ##1 network_indicator)
    else $error("voice call not shown steady high");
  a_status_cause: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(status_out) |-> $past(powerup_done))
    else $error("status rose without power-up");
  a_ri_idle_high: assert property (@(posedge clk) disable iff (!rst_b)
    pins_configured && !ri_busy_q && !urc_any |=> ring_indicator_out)
    else $error("ring indicator not idle high");
  a_ri_pulse_len: assert property (@(posedge clk) disable iff (!rst_b)
    pins_configured && !ring_indicator_out |-> ri_cnt_q < RI_LOW_MS)
    else $error("ring pulse too long");
  a_ri_any_port: assert property (@(posedge clk) disable iff (!rst_b)
    pins_configured && urc_any |=> !ring_indicator_out)
    else $error("result did not start ring pulse");
  a_wake_exit: assert property (@(posedge clk) disable iff (!rst_b)
    sleep_q == SLP_DEEP && (sleep_wake_input || wake_timer_expired) |=> sleep_q == SLP_NORMAL ##1 !sleep_mode_indicator)
    else $error("wake did not leave deep sleep");
  a_sleep_ind: assert property (@(posedge clk) disable iff (!rst_b)
    sleep_q == SLP_DEEP |=> sleep_mode_indicator)
    else $error("sleep indicator not set");
  a_entry_order: assert property (@(posedge clk) disable iff (!rst_b)
    $rose(sleep_q == SLP_DEEP) |-> $past(sleep_q) == SLP_ARMED)
    else $error("deep sleep entered out of order");
  a_powerup_pins: assert property (@(posedge clk) disable iff (!rst_b)
    pu_q != PU_RUN |-> ring_indicator_out == (pu_q == PU_HIGH) && !host_ready)
    else $error("power-up pin phase wrong");

  c_deep_sleep: cover property (@(posedge clk) disable iff (!rst_b) $rose(sleep_q == SLP_DEEP));
  c_ri_pulse: cover property (@(posedge clk) disable iff (!rst_b) $rose(ring_indicator_out) && pins_configured);
  c_data_blink: cover property (@(posedge clk) disable iff (!rst_b) mode_q == NET_DATA && $rose(phase_q));
  c_pins_ready: cover property (@(posedge clk) disable iff (!rst_b) $rose(pins_configured));

endmodule
`default_nettype wire

// *** msi_pkg.sv ***
`default_nettype none
package msi_pkg;

  // clock and millisecond tick
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DFLT = CLK_HZ / MS_PER_S;
  localparam int TICK_W = 15;

  // pattern and pulse times in ms
  localparam int MS_W = 12;
  localparam logic [MS_W-1:0] MS_ZERO = 12'h000;
  localparam logic [MS_W-1:0] MS_ONE = 12'h001;
  localparam logic [MS_W-1:0] SEARCH_HIGH_MS = 12'h0C8;
  localparam logic [MS_W-1:0] SEARCH_LOW_MS = 12'h708;
  localparam logic [MS_W-1:0] REG_HIGH_MS = 12'h0EA;
  localparam logic [MS_W-1:0] REG_LOW_MS = 12'h10A;
  localparam logic [MS_W-1:0] DATA_LOW_MS = 12'h03F;
  localparam logic [MS_W-1:0] DATA_HIGH_MS = 12'h03E;
  localparam logic [MS_W-1:0] RI_LOW_MS = 12'h078;
  // 2 s high, then 1.2 s low
  localparam logic [MS_W-1:0] PWRUP_HIGH_MS = 12'h7D0;
  localparam logic [MS_W-1:0] PWRUP_LOW_MS = 12'h4B0;

  localparam int URC_PORTS = 3;

  typedef enum logic [4:0] {
    NET_OFF    = 5'b00001,
    NET_SEARCH = 5'b00010,
    NET_REG    = 5'b00100,
    NET_DATA   = 5'b01000,
    NET_VOICE  = 5'b10000
  } msi_net_e;

  typedef enum logic [3:0] {
    SLP_NORMAL   = 4'b0001,
    SLP_AIRPLANE = 4'b0010,
    SLP_ARMED    = 4'b0100,
    SLP_DEEP     = 4'b1000
  } msi_sleep_e;

  typedef enum logic [2:0] {
    PU_HIGH = 3'b001,
    PU_LOW  = 3'b010,
    PU_RUN  = 3'b100
  } msi_pu_e;

endpackage
`default_nettype wire

// *** msi_host_model.sv ***
`default_nettype none
module msi_host_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // requests from the bench
  input wire logic sleep_req,
  input wire logic psm_only,
  input wire logic wake_req,
  input wire logic ready_req,
  // toward the device
  output logic cmd_airplane_on,
  output logic cmd_psm_enable,
  output logic cmd_airplane_off,
  output logic sleep_wake_input,
  output logic host_ready_input
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] seq_q;

  ////////////////////////////////////////////////////////////////
  // command sequence, one command per cycle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seq_q <= 2'h0;
    end else if (seq_q != 2'h0) begin
      seq_q <= seq_q + 2'h1;
    end else if (sleep_req) begin
      seq_q <= 2'h1;
    end
  end

  assign cmd_airplane_on = (seq_q == 2'h1);
  assign cmd_psm_enable = (seq_q == 2'h2) || psm_only;
  assign cmd_airplane_off = (seq_q == 2'h3);

  ////////////////////////////////////////////////////////////////
  // wake pin and host ready level
  assign sleep_wake_input = wake_req;
  assign host_ready_input = ready_req;
endmodule
`default_nettype wire

// *** tb.sv ***
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import msi_pkg::*;
  localparam int MSC = 4;
  logic clk = 1'b0, rst_b = 1'b0;
  logic net_searching = 1'b0, net_registered = 1'b0, data_active = 1'b0, voice_call = 1'b0;
  logic powerup_done = 1'b0, wake_timer_expired = 1'b0;
  logic sleep_req = 1'b0, psm_only = 1'b0, wake_req = 1'b0, ready_req = 1'b1;
  logic [URC_PORTS-1:0] urc_event = '0;
  logic network_indicator, status_out, ring_indicator_out, sleep_mode_indicator, host_ready, pins_configured;
  logic cmd_airplane_on, cmd_psm_enable, cmd_airplane_off, sleep_wake_input, host_ready_input;
  int n_mismatch = 0;
  int cmp_count = 0;

  always #25 clk = ~clk;

  msi_status_indicators #(.MS_CYCLES(MSC)) uut (.clk(clk), .rst_b(rst_b),
    .net_searching(net_searching), .net_registered(net_registered), .data_active(data_active),
    .voice_call(voice_call), .network_indicator(network_indicator), .powerup_done(powerup_done),
    .status_out(status_out), .urc_event(urc_event), .ring_indicator_out(ring_indicator_out),
    .cmd_airplane_on(cmd_airplane_on), .cmd_psm_enable(cmd_psm_enable), .cmd_airplane_off(cmd_airplane_off),
    .wake_timer_expired(wake_timer_expired), .sleep_wake_input(sleep_wake_input),
    .sleep_mode_indicator(sleep_mode_indicator), .host_ready_input(host_ready_input),
    .host_ready(host_ready), .pins_configured(pins_configured));

  msi_host_model host (.clk(clk), .rst_b(rst_b), .sleep_req(sleep_req), .psm_only(psm_only),
    .wake_req(wake_req), .ready_req(ready_req), .cmd_airplane_on(cmd_airplane_on),
    .cmd_psm_enable(cmd_psm_enable), .cmd_airplane_off(cmd_airplane_off),
    .sleep_wake_input(sleep_wake_input), .host_ready_input(host_ready_input));

  ////////////////////////////////////////////////////////////////
  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches=%0d compares=%0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////
  // one ring pulse, expected 119..120 ms low
  task automatic t_ring(input logic [URC_PORTS-1:0] p);
    urc_event = p;
    step(1);
    urc_event = '0;
    chk(ring_indicator_out, 1'b0);
    step(118 * MSC);
    chk(ring_indicator_out, 1'b0);
    step(4 * MSC);
    chk(ring_indicator_out, 1'b1);
    $display("test ring %h done", p);
  endtask

  // first phase is not tick aligned: skip it, then time a full high and a full low phase
  task automatic t_net(input logic [3:0] m, input int hi, input int lo);
    int n;
    {voice_call, data_active, net_registered, net_searching} = m;
    step(3);
    n = 0;
    while (network_indicator === 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    while (network_indicator === 1'b0 && n < 20000) begin
      step(1);
      n++;
    end
    n = 0;
    while (network_indicator === 1'b1 && n < 20000) begin
      step(1);
      n++;
    end
    chk(n, hi);
    n = 0;
    while (network_indicator === 1'b0 && n < 20000) begin
      step(1);
      n++;
    end
    chk(n, lo);
    $display("test net %h done", m);
  endtask

  task automatic t_voice();
    {voice_call, data_active, net_registered, net_searching} = 4'h0;
    step(3);
    chk(network_indicator, 1'b0);
    {voice_call, data_active} = 2'h3;
    step(3);
    for (int i = 0; i < 8; i++) begin
      chk(network_indicator, 1'b1);
      step(50);
    end
    $display("test voice done");
  endtask

  task automatic t_sleep(input logic by_timer);
    psm_only = 1'b1;
    step(1);
    psm_only = 1'b0;
    step(3);
    chk(sleep_mode_indicator, 1'b0);
    sleep_req = 1'b1;
    step(1);
    sleep_req = 1'b0;
    step(5);
    chk(sleep_mode_indicator, 1'b1);
    wake_req = !by_timer;
    wake_timer_expired = by_timer;
    step(1);
    {wake_req, wake_timer_expired} = 2'h0;
    step(2);
    chk(sleep_mode_indicator, 1'b0);
    $display("test sleep %0d done", by_timer);
  endtask

  ////////////////////////////////////////////////////////////////
  initial begin
    #5_000_000;
    n_mismatch++;
    finish_test();
  end

  initial begin
    step(20);
    chk(ring_indicator_out, 1'b1);
    chk({status_out, pins_configured, sleep_mode_indicator}, 3'h0);
    rst_b = 1'b1;
    step(7900);
    chk({ring_indicator_out, pins_configured, host_ready}, 3'h4);
    step(200);
    chk(ring_indicator_out, 1'b0);
    step(4590);
    chk(pins_configured, 1'b0);
    urc_event = '1;
    step(1);
    urc_event = '0;
    step(200);
    chk({ring_indicator_out, pins_configured, host_ready}, 3'h7);
    $display("test power-up done");
    chk(status_out, 1'b0);
    powerup_done = 1'b1;
    step(1);
    powerup_done = 1'b0;
    step(5);
    chk(status_out, 1'b1);
    $display("test status done");
    for (int i = 0; i < URC_PORTS; i++) t_ring(URC_PORTS'(1 << i));
    t_ring('1);
    t_net(4'h1, 200 * MSC, 1800 * MSC);
    t_net(4'h3, 234 * MSC, 266 * MSC);
    t_net(4'h7, 62 * MSC, 63 * MSC);
    t_voice();
    t_sleep(1'b0);
    t_sleep(1'b1);
    finish_test();
  end
endmodule
`default_nettype wire
